// ---- logic/tpc_chan.v ----
/*
 * one timer channel: pin synchroniser, input capture, output compare,
 * edge-aligned and center-aligned pwm, channel value and flag.
 * assumes the counter, its update strobe and direction come from the
 * timer core on the same clock; the pin input is asynchronous.
 */
`timescale 1ns/1ps
`include "tpc_defs.vh"

module tpc_chan (
    input wire mclk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire timer_on_i,
    input wire cnt_upd_i,
    input wire count_down_i,
    input wire center_align_select_i,
    input wire [`TPC_CW-1:0] cnt_i,
    input wire [1:0] channel_mode_select_i,
    input wire [1:0] edge_level_select_i,
    input wire value_wr_i,
    input wire [`TPC_CW-1:0] value_wdata_i,
    input wire flag_clear_i,
    input wire pin_i,
    output wire [`TPC_CW-1:0] value_o,
    output wire flag_o,
    output wire pin_o,
    output wire pin_oe_n_o
);

    reg sync1_q;
    reg sync2_q;
    reg sync3_q;
    reg [`TPC_CW-1:0] value_q;
    reg flag_q;
    reg pin_q;
    reg pin_d;
    reg oe_n_q;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire els_on = (edge_level_select_i != `TPC_ELS_NONE);
    wire cap_mode = !center_align_select_i && els_on
                    && (channel_mode_select_i == `TPC_MODE_CAP);
    wire cmp_mode = !center_align_select_i
                    && (channel_mode_select_i == `TPC_MODE_CMP);
    wire epwm_mode = !center_align_select_i && els_on
                     && channel_mode_select_i[`TPC_MODE_PWM_BIT];
    wire cpwm_mode = center_align_select_i && els_on;
    wire pol = edge_level_select_i[`TPC_ELS_POL_BIT];

    // match only on the cycle the counter took a new value
    wire match = timer_on_i && cnt_upd_i && (cnt_i == value_q);
    wire rise = sync2_q & ~sync3_q;
    wire fall = ~sync2_q & sync3_q;
    wire cap_evt = timer_on_i && cap_mode
                   && ((edge_level_select_i[`TPC_ELS_RISE_BIT] & rise)
                   | (edge_level_select_i[`TPC_ELS_FALL_BIT] & fall));
    wire cmp_evt = match && (cmp_mode || epwm_mode || cpwm_mode);
    wire period_start = timer_on_i && epwm_mode && cnt_upd_i
                        && (cnt_i == `TPC_CNT_ZERO);

    // ------------------------------------------------------------------
    // pin level chosen by the active mode
    // ------------------------------------------------------------------
    always @* begin
        pin_d = pin_q;
        if (cmp_mode && match) begin
            case (edge_level_select_i)
                `TPC_ELS_TOGGLE: pin_d = ~pin_q;
                `TPC_ELS_CLEAR: pin_d = 1'b0;
                `TPC_ELS_SET: pin_d = 1'b1;
                default: pin_d = pin_q;
            endcase
        end else if (epwm_mode) begin
            // match after period start so a zero value gives zero duty
            if (period_start)
                pin_d = ~pol;
            if (match)
                pin_d = pol;
        end else if (cpwm_mode && match) begin
            pin_d = count_down_i ? ~pol : pol;
        end
    end

    // ------------------------------------------------------------------
    // registers: synchroniser, value, flag, pin drive
    // ------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            value_q <= `TPC_CNT_ZERO;
            flag_q <= 1'b0;
            pin_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else if (clk_en_i) begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (cap_evt)
                value_q <= cnt_i;
            else if (value_wr_i)
                value_q <= value_wdata_i;
            if (cap_evt || cmp_evt)
                flag_q <= 1'b1;
            else if (flag_clear_i)
                flag_q <= 1'b0;
            pin_q <= pin_d;
            // released unless a driving function is enabled
            oe_n_q <= !(timer_on_i && els_on && !cap_mode);
        end
    end

    assign value_o = value_q;
    assign flag_o = flag_q;
    assign pin_o = pin_q;
    assign pin_oe_n_o = oe_n_q;

endmodule // tpc_chan

// ---- logic/tpc_defs.vh ----
/*
 * constants shared by the timer, its channels and the bench: widths,
 * clock source codes, channel mode and edge/level codes, reset values.
 * assumes it is included by bare name from each design file.
 */
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define TPC_NCH 8
`define TPC_CW 16
`define TPC_PW 7

// ----------------------------------------------------------------------
// counter clock source select
// ----------------------------------------------------------------------
`define TPC_CLK_OFF 2'h0
`define TPC_CLK_BUS 2'h1
`define TPC_CLK_FIX 2'h2
`define TPC_CLK_EXT 2'h3

// ----------------------------------------------------------------------
// channel mode select (bit 1 set means edge-aligned pwm)
// ----------------------------------------------------------------------
`define TPC_MODE_CAP 2'h0
`define TPC_MODE_CMP 2'h1
`define TPC_MODE_PWM_BIT 1

// ----------------------------------------------------------------------
// edge/level select
// ----------------------------------------------------------------------
`define TPC_ELS_NONE 2'h0
`define TPC_ELS_TOGGLE 2'h1
`define TPC_ELS_CLEAR 2'h2
`define TPC_ELS_SET 2'h3
`define TPC_ELS_RISE_BIT 0
`define TPC_ELS_FALL_BIT 1
`define TPC_ELS_POL_BIT 0

// ----------------------------------------------------------------------
// counter and prescaler values
// ----------------------------------------------------------------------
`define TPC_CNT_ZERO 16'h0000
`define TPC_CNT_ONE 16'h0001
`define TPC_CNT_FULL 16'hFFFF
`define TPC_PRE_ZERO 7'h00
`define TPC_PRE_ONE 7'h01
`define TPC_PRE_ALL 7'h7F

`endif

// ---- logic/tpc_timer.v ----
/*
 * timer core: clock source select, clock synchronisers, prescaler,
 * 16-bit up or up/down counter, terminal count flag, interrupt
 * requests and eight channels.
 * assumes control inputs come from logic on mclk_i; the fixed clock,
 * the external clock and channel pins are asynchronous.
 */
`timescale 1ns/1ps
`include "tpc_defs.vh"

module tpc_timer (
    input wire mclk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire background_debug_mode_i,
    input wire [1:0] clock_source_sel_i,
    input wire [2:0] prescale_sel_i,
    input wire [`TPC_CW-1:0] counter_modulo_value_i,
    input wire center_align_select_i,
    input wire count_reset_wr_i,
    input wire fixed_clock_i,
    input wire external_timer_clock_in_i,
    input wire [2*`TPC_NCH-1:0] channel_mode_select_i,
    input wire [2*`TPC_NCH-1:0] edge_level_select_i,
    input wire [`TPC_NCH-1:0] chan_value_wr_i,
    input wire [`TPC_CW-1:0] chan_value_wdata_i,
    input wire [`TPC_NCH-1:0] chan_flag_clear_i,
    input wire [`TPC_NCH-1:0] chan_irq_en_i,
    input wire overflow_clear_i,
    input wire overflow_irq_en_i,
    input wire [`TPC_NCH-1:0] timer_channel_pin_i,
    output wire [`TPC_NCH-1:0] timer_channel_pin_o,
    output wire [`TPC_NCH-1:0] timer_channel_pin_oe_n_o,
    output wire [`TPC_CW*`TPC_NCH-1:0] chan_value_o,
    output wire [`TPC_NCH-1:0] chan_flag_o,
    output wire [`TPC_NCH-1:0] chan_irq_o,
    output wire [`TPC_CW-1:0] timer_count_value_o,
    output wire count_down_o,
    output wire overflow_flag_o,
    output wire overflow_irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg fix1_q;
    reg fix2_q;
    reg fix3_q;
    reg ext1_q;
    reg ext2_q;
    reg ext3_q;
    reg [`TPC_PW-1:0] pre_q;
    reg [`TPC_PW-1:0] pre_d;
    reg [`TPC_CW-1:0] cnt_q;
    reg [`TPC_CW-1:0] cnt_d;
    reg down_q;
    reg down_d;
    reg wrap_d;
    reg cnt_upd_q;
    reg ovf_q;
    reg ovf_irq_q;
    reg [`TPC_NCH-1:0] chan_irq_q;
    reg src_tick;

    // ------------------------------------------------------------------
    // clock source and prescaler tick
    // ------------------------------------------------------------------
    // timer is disabled while no clock source is selected
    wire timer_on = (clock_source_sel_i != `TPC_CLK_OFF);
    // wait mode has no input here, so the timer runs through it
    wire run = timer_on && !background_debug_mode_i;

    // one source tick per counter clock event
    always @* begin
        case (clock_source_sel_i)
            `TPC_CLK_BUS: src_tick = 1'b1;
            `TPC_CLK_FIX: src_tick = fix2_q & ~fix3_q;
            `TPC_CLK_EXT: src_tick = ext2_q & ~ext3_q;
            default: src_tick = 1'b0;
        endcase
    end

    // mask of low prescaler bits that must all be set for a tick
    wire [`TPC_PW-1:0] pre_mask = ~(`TPC_PRE_ALL << prescale_sel_i);
    wire pre_tick = run && src_tick && ((pre_q & pre_mask) == pre_mask);

    // zero and all ones both mean full range
    wire [`TPC_CW-1:0] mod_eff = ((counter_modulo_value_i == `TPC_CNT_ZERO)
                                 || (counter_modulo_value_i == `TPC_CNT_FULL))
                                 ? `TPC_CNT_FULL : counter_modulo_value_i;

    // ------------------------------------------------------------------
    // counter next state
    // ------------------------------------------------------------------
    always @* begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        down_d = down_q;
        wrap_d = 1'b0;
        if (count_reset_wr_i) begin
            // written data is not used, only the strobe
            pre_d = `TPC_PRE_ZERO;
            cnt_d = `TPC_CNT_ZERO;
            down_d = 1'b0;
        end else begin
            if (run && src_tick)
                pre_d = pre_q + `TPC_PRE_ONE;
            if (pre_tick) begin
                if (!center_align_select_i) begin
                    down_d = 1'b0;
                    if (cnt_q == mod_eff) begin
                        cnt_d = `TPC_CNT_ZERO;
                        wrap_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + `TPC_CNT_ONE;
                    end
                end else if (!down_q) begin
                    // turn at the modulo, also if it was lowered below us
                    if (cnt_q >= mod_eff) begin
                        down_d = 1'b1;
                        cnt_d = cnt_q - `TPC_CNT_ONE;
                    end else begin
                        cnt_d = cnt_q + `TPC_CNT_ONE;
                    end
                end else begin
                    if (cnt_q == `TPC_CNT_ZERO) begin
                        down_d = 1'b0;
                        cnt_d = `TPC_CNT_ONE;
                        wrap_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q - `TPC_CNT_ONE;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // clocked state: synchronisers, prescaler, counter, flags
    // ------------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            fix1_q <= 1'b0;
            fix2_q <= 1'b0;
            fix3_q <= 1'b0;
            ext1_q <= 1'b0;
            ext2_q <= 1'b0;
            ext3_q <= 1'b0;
            pre_q <= `TPC_PRE_ZERO;
            cnt_q <= `TPC_CNT_ZERO;
            down_q <= 1'b0;
            cnt_upd_q <= 1'b0;
            ovf_q <= 1'b0;
            ovf_irq_q <= 1'b0;
            chan_irq_q <= {`TPC_NCH{1'b0}};
        end else if (clk_en_i) begin
            // fixed and external clocks enter through three flops each, the last for edge detect
            fix1_q <= fixed_clock_i;
            fix2_q <= fix1_q;
            fix3_q <= fix2_q;
            ext1_q <= external_timer_clock_in_i;
            ext2_q <= ext1_q;
            ext3_q <= ext2_q;
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            down_q <= down_d;
            cnt_upd_q <= pre_tick && !count_reset_wr_i;
            // a wrap in the clearing cycle keeps the flag set
            if (wrap_d)
                ovf_q <= 1'b1;
            else if (overflow_clear_i)
                ovf_q <= 1'b0;
            ovf_irq_q <= ovf_q & overflow_irq_en_i;
            chan_irq_q <= chan_flag_o & chan_irq_en_i;
        end
    end

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `TPC_NCH; g = g + 1) begin : g_chan
            tpc_chan u_chan (
                .mclk_i(mclk_i),
                .rst_n_i(rst_n_i),
                .clk_en_i(clk_en_i),
                .timer_on_i(timer_on),
                .cnt_upd_i(cnt_upd_q),
                .count_down_i(down_q),
                .center_align_select_i(center_align_select_i),
                .cnt_i(cnt_q),
                .channel_mode_select_i(channel_mode_select_i[2*g+1:2*g]),
                .edge_level_select_i(edge_level_select_i[2*g+1:2*g]),
                .value_wr_i(chan_value_wr_i[g]),
                .value_wdata_i(chan_value_wdata_i),
                .flag_clear_i(chan_flag_clear_i[g]),
                .pin_i(timer_channel_pin_i[g]),
                .value_o(chan_value_o[`TPC_CW*g+`TPC_CW-1:`TPC_CW*g]),
                .flag_o(chan_flag_o[g]),
                .pin_o(timer_channel_pin_o[g]),
                .pin_oe_n_o(timer_channel_pin_oe_n_o[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // count is a plain flop read, reading has no side effect
    assign timer_count_value_o = cnt_q;
    assign count_down_o = down_q;
    assign overflow_flag_o = ovf_q;
    assign overflow_irq_o = ovf_irq_q;
    assign chan_irq_o = chan_irq_q;

endmodule // tpc_timer

// ---- verif/test_tpc_timer.sv ----
/* self-checking bench for the timer core.
   assumes tpc_pin_model supplies pin levels and the slow clocks. */
`timescale 1ns/1ps
`include "tpc_defs.vh"
module test_tpc_timer;
    reg mclk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, background_debug_mode_i = 1'b0;
    reg center_align_select_i = 1'b0, count_reset_wr_i = 1'b0, clk_run = 1'b0;
    reg overflow_clear_i = 1'b0, overflow_irq_en_i = 1'b1;
    reg [1:0] clock_source_sel_i = 2'h0, e;
    reg [2:0] prescale_sel_i = 3'h0;
    reg [15:0] counter_modulo_value_i = 16'h0000, chan_value_wdata_i = 16'h0000, v;
    reg [15:0] channel_mode_select_i = 16'h0000, edge_level_select_i = 16'h0000;
    reg [7:0] chan_value_wr_i = 8'h00, chan_flag_clear_i = 8'h00, chan_irq_en_i = 8'hFF;
    reg [7:0] drv = 8'h00;
    wire fixed_clock_i, external_timer_clock_in_i, count_down_o, overflow_flag_o, overflow_irq_o;
    wire [7:0] timer_channel_pin_i, timer_channel_pin_o, timer_channel_pin_oe_n_o;
    wire [7:0] chan_flag_o, chan_irq_o;
    wire [127:0] chan_value_o;
    wire [15:0] timer_count_value_o;
    wire [8:0] flags = {overflow_flag_o, chan_flag_o};
    integer err_count = 0, samples_checked = 0, cycles = 0, i, k, c;

    tpc_timer tpc_timer_i (.*);
    tpc_pin_model tpc_pin_model_i (.clk_run_i(clk_run), .drive_i(drv),
        .tmr_pin_i(timer_channel_pin_o), .tmr_oe_n_i(timer_channel_pin_oe_n_o),
        .pin_o(timer_channel_pin_i), .fix_clk_o(fixed_clock_i),
        .ext_clk_o(external_timer_clock_in_i));

    // ----------------------------------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------------------------------
    // clock and hang guard
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            summarize;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge mclk_i);
    endtask
    task clr_cnt;
        count_reset_wr_i = 1'b1;
        cyc(1);
        count_reset_wr_i = 1'b0;
    endtask
    task clrf;
        chan_flag_clear_i = 8'hFF;
        overflow_clear_i = 1'b1;
        cyc(1);
        chan_flag_clear_i = 8'h00;
        overflow_clear_i = 1'b0;
    endtask
    task setv(input integer ch, input [15:0] val);
        chan_value_wdata_i = val;
        chan_value_wr_i = 8'h01 << ch;
        cyc(1);
        chan_value_wr_i = 8'h00;
    endtask
    task chcfg(input integer ch, input [1:0] m, input [1:0] el);
        channel_mode_select_i[2*ch+:2] = m;
        edge_level_select_i[2*ch+:2] = el;
    endtask
    task waitf(input integer n);
        k = 0;
        while (flags[n] !== 1'b1 && k < 300) begin
            cyc(1);
            k = k + 1;
        end
        check(k < 300, 1'b1);
    endtask
    task hi(input integer ch, input integer n);
        c = 0;
        repeat (n) begin
            cyc(1);
            c = c + timer_channel_pin_o[ch];
        end
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(2);
        rst_n_i = 1'b1;
        check(timer_channel_pin_oe_n_o, 8'hFF);
        check(flags, 9'h000);
        clock_source_sel_i = `TPC_CLK_BUS;
        counter_modulo_value_i = 16'h0003;
        clr_cnt;
        waitf(8);
        check(timer_count_value_o, 16'h0000);
        cyc(1);
        check(overflow_irq_o, 1'b1);
        // interval between counter steps for each divide ratio
        counter_modulo_value_i = 16'h0000;
        for (i = 0; i < 8; i = i + 1) begin
            prescale_sel_i = i[2:0];
            clr_cnt;
            repeat (2) begin
                v = timer_count_value_o;
                k = 0;
                while (timer_count_value_o === v && k < 300) begin
                    cyc(1);
                    k = k + 1;
                end
            end
            check(k, 1 << i);
        end
        prescale_sel_i = 3'h0;
        background_debug_mode_i = 1'b1;
        cyc(2);
        v = timer_count_value_o;
        cyc(10);
        check(timer_count_value_o, v);
        background_debug_mode_i = 1'b0;
        cyc(3);
        check(timer_count_value_o, v + 16'h0003);
        // compare actions: set, toggle, toggle, clear
        for (i = 0; i < 4; i = i + 1) begin
            e = 2'(8'h97 >> (2 * i));
            chcfg(0, `TPC_MODE_CMP, e);
            setv(0, 16'h0040);
            clr_cnt;
            clrf;
            cyc(2);
            if (i > 0) check(timer_channel_pin_o[0], i[0]);
            waitf(0);
            if (i == 0) check(timer_count_value_o, 16'h0041);
            check(chan_value_o[15:0], 16'h0040);
            check(timer_channel_pin_o[0], i[0] == 1'b0);
        end
        cyc(1);
        check(chan_irq_o[0], 1'b1);
        chcfg(0, `TPC_MODE_CMP, `TPC_ELS_NONE);
        clr_cnt;
        clrf;
        cyc(2);
        waitf(0);
        check(timer_channel_pin_oe_n_o[0], 1'b1);
        // capture: each edge select against a rising then a falling edge
        for (i = 0; i < 8; i = i + 1) begin
            e = 2'(8'h39 >> (2 * (i / 2)));
            chcfg(1, `TPC_MODE_CAP, e);
            clrf;
            cyc(2);
            v = timer_count_value_o;
            drv[1] = ~drv[1];
            cyc(8);
            check(chan_flag_o[1], e[i % 2]);
            if (e[i % 2]) check(chan_value_o[31:16] - v <= 16'h0004 &&
                chan_value_o[31:16] - v >= 16'h0002, 1'b1);
        end
        check(timer_channel_pin_oe_n_o[1], 1'b1);
        // edge pwm duty 0, 5 and above modulo, then low-true
        counter_modulo_value_i = 16'h0008;
        chcfg(2, 2'h2, `TPC_ELS_CLEAR);
        for (i = 0; i < 3; i = i + 1) begin
            v = (16'h0950 >> (4 * i)) & 16'h000F;
            setv(2, v);
            clr_cnt;
            cyc(12);
            hi(2, 18);
            check(c, 2 * v);
        end
        setv(2, 16'h0005);
        chcfg(2, 2'h2, `TPC_ELS_TOGGLE);
        cyc(12);
        hi(2, 18);
        check(c, 8);
        // duty-end and period-end events both raise their flags
        clrf;
        cyc(12);
        check({chan_flag_o[2], overflow_flag_o}, 2'h3);
        // center pwm on channels 2 and 4
        chcfg(2, 2'h2, `TPC_ELS_CLEAR);
        chcfg(4, `TPC_MODE_CAP, `TPC_ELS_CLEAR);
        center_align_select_i = 1'b1;
        clr_cnt;
        cyc(20);
        hi(2, 32);
        check(c, 20);
        // 58 ticks after the clear: counting down through 6
        cyc(6);
        check({count_down_o, timer_count_value_o}, 17'h10006);
        check(timer_channel_pin_oe_n_o[4], 1'b0);
        // fixed and external sources
        center_align_select_i = 1'b0;
        counter_modulo_value_i = 16'h0000;
        clk_run = 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            clock_source_sel_i = i ? `TPC_CLK_EXT : `TPC_CLK_FIX;
            clr_cnt;
            cyc(100);
            k = i ? 25 : 20;
            check(timer_count_value_o > k - 3 && timer_count_value_o < k + 2, 1'b1);
        end
        clk_run = 1'b0;
        clock_source_sel_i = `TPC_CLK_OFF;
        cyc(3);
        check(timer_channel_pin_oe_n_o, 8'hFF);
        summarize;
    end
endmodule // test_tpc_timer

bind tpc_timer tpc_timer_asserts tpc_timer_asserts_i (.*);

// ---- verif/tpc_pin_model.sv ----
/* far side of the channel pins and the two slow clock sources.
   assumes the bench commands the drive levels and clock run. */
`timescale 1ns/1ps
`include "tpc_defs.vh"
module tpc_pin_model (
    input wire clk_run_i,
    input wire [`TPC_NCH-1:0] drive_i,
    input wire [`TPC_NCH-1:0] tmr_pin_i,
    input wire [`TPC_NCH-1:0] tmr_oe_n_i,
    output wire [`TPC_NCH-1:0] pin_o,
    output reg fix_clk_o = 1'b0,
    output reg ext_clk_o = 1'b0
);
    // ----------------------------------------------------------------
    // pins and clocks
    // ----------------------------------------------------------------
    // timer wins while it drives, otherwise the outside source
    assign pin_o = (~tmr_oe_n_i & tmr_pin_i) | (tmr_oe_n_i & drive_i);
    // slow clocks stand low when stopped; external at a quarter of bus rate
    always #25 fix_clk_o = clk_run_i & ~fix_clk_o;
    always #20 ext_clk_o = clk_run_i & ~ext_clk_o;
endmodule // tpc_pin_model

// ---- verif/tpc_timer_asserts.sv ----
/* concurrent checks on the timer core ports.
   assumes a bind onto tpc_timer from the bench top; one clock domain. */
`timescale 1ns/1ps
`include "tpc_defs.vh"
module tpc_timer_asserts (
    input wire mclk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire background_debug_mode_i,
    input wire [1:0] clock_source_sel_i,
    input wire [2:0] prescale_sel_i,
    input wire [15:0] counter_modulo_value_i,
    input wire center_align_select_i,
    input wire count_reset_wr_i,
    input wire [15:0] channel_mode_select_i,
    input wire [7:0] chan_irq_en_i,
    input wire overflow_irq_en_i,
    input wire [7:0] timer_channel_pin_oe_n_o,
    input wire [7:0] chan_flag_o,
    input wire [7:0] chan_irq_o,
    input wire [15:0] timer_count_value_o,
    input wire overflow_flag_o,
    input wire overflow_irq_o
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one counter tick per clock: bus source, divide by one
    wire tick = clk_en_i && !background_debug_mode_i && !count_reset_wr_i &&
        clock_source_sel_i == `TPC_CLK_BUS && prescale_sel_i == 3'h0;
    wire [15:0] md = counter_modulo_value_i;
    wire full = md == 16'h0000 || md == 16'hFFFF;
    wire [15:0] cnt = timer_count_value_o;
    wire up = !center_align_select_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    // counting, wrap and turnaround
    up_wrap_a:
    assert property (tick && up && !full && cnt == md |=> cnt == 16'h0000 && overflow_flag_o)
        else $error("counter did not wrap at modulo");
    up_step_a:
    assert property (tick && up && (full || cnt != md) |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter did not step by one");
    center_turn_a:
    assert property (tick && !up && md > 16'h0001 && md != 16'hFFFF && cnt == md
        |=> cnt == $past(md) - 16'h0001) else $error("no turnaround at modulo");
    dbg_hold_a:
    assert property (clk_en_i && background_debug_mode_i && !count_reset_wr_i |=> $stable(cnt))
        else $error("counter moved in debug");
    cnt_clear_a:
    assert property (clk_en_i && count_reset_wr_i |=> cnt == 16'h0000)
        else $error("counter write did not clear");
    // requests follow flags one cycle later
    ovf_irq_a:
    assert property (clk_en_i |=> overflow_irq_o == $past(overflow_flag_o && overflow_irq_en_i))
        else $error("terminal request wrong");
    ch_irq_a:
    assert property (clk_en_i |=> chan_irq_o == $past(chan_flag_o & chan_irq_en_i))
        else $error("channel request wrong");
    // pin release
    pins_off_a:
    assert property ((clock_source_sel_i == `TPC_CLK_OFF) [*2] |-> &timer_channel_pin_oe_n_o)
        else $error("pins driven while disabled");
    cap_release_a:
    assert property ((up && channel_mode_select_i[1:0] == `TPC_MODE_CAP) [*2]
        |-> timer_channel_pin_oe_n_o[0]) else $error("capture pin driven");
    // main scenarios reached
    cover property ($rose(overflow_flag_o));
    cover property ($rose(chan_flag_o[1]));
    cover property (tick && !up && cnt == md);
endmodule // tpc_timer_asserts
